// file: logic/rtpc_cfg.svh
`ifndef RTPC_CFG_SVH
`define RTPC_CFG_SVH

// command codes, sent msb first
`define RTPC_OP_VEIL 16'hE001
`define RTPC_OP_UNVEIL 16'hE002
`define RTPC_OP_FLAG 16'hE003

// frame lengths in bits, frame-sync excluded
`define RTPC_LEN_VEIL 48
`define RTPC_LEN_UNVEIL 80
`define RTPC_LEN_FLAG 49
`define RTPC_FIELD_W 16

// crc-16: preset, polynomial, good residue at the receiver
`define RTPC_CRC_PRESET 16'hFFFF
`define RTPC_CRC_POLY 16'h1021
`define RTPC_CRC_RESIDUE 16'h1D0F

// feature configuration word in the item-code bank
`define RTPC_CFG_WORD_ADDR 16'h0200
// positions inside the local 3-bit copy of the word
`define RTPC_POS_ITEM_HIDE 2
`define RTPC_POS_IDENT_HIDE 1
`define RTPC_POS_PSF 0
`define RTPC_CFG_RST 3'h0

// reply framing
`define RTPC_ERR_CODE 8'h0F
`define RTPC_OK_LEN 17
`define RTPC_ERR_LEN 25

// reply deadline
`define RTPC_REPLY_LIMIT_MS 20
`define RTPC_SYS_CLK_MHZ 200

`endif

// file: logic/rtpc_cmd_handler.sv
// Notes on behaviour
// - veil frame: code E001, handle, crc
// - veil in secured sets both hide bits
// - veil ignored when access password zero
// - valid unveil clears both hide bits
// - unveil frame: code, masked password, handle, crc
// - crc covers code through handle; bad ignored
// - unveil open/secured with good password replies
// - unveil wrong password: silent, go arbitrate
// - frame-sync must precede every command
// - reply: zero bit, handle, crc-16
// - replies always carry extended pilot preamble
// - write error sends error code instead
// - flag command secured only, nonzero password
// - flag with bad crc or handle ignored
// - flag command sets or clears status flag
// - flag frame: code E003, bit, handle, crc
// - status flag enables alarm from next power-up
// - alarm answered without select or inventory
// - config word selectable, item code returned
// - config word at item-code address 200h
`timescale 1ns/100ps
`include "rtpc_cfg.svh"

module rtpc_cmd_handler
    import rtpc_pkg::*;
#(
    parameter int unsigned P_TIMEOUT_CYC = `RTPC_REPLY_LIMIT_MS * 1000 * `RTPC_SYS_CLK_MHZ
) (
    input wire logic I_SYS_CLK,
    input wire logic I_RST_N,
    input wire logic I_CLK_EN,
    input wire logic I_FRAME_SYNC,
    input wire logic I_BIT_VALID,
    input wire logic I_BIT_DATA,
    input wire logic I_FRAME_END,
    input wire rtpc_tag_state_t I_TAG_STATE,
    input wire logic [15:0] I_HANDLE,
    input wire logic [15:0] I_RN16,
    input wire logic I_RN16_FRESH,
    input wire logic [31:0] I_ACCESS_PWD,
    input wire logic I_NVM_LOAD,
    input wire logic [2:0] I_NVM_CFG,
    input wire logic I_NVM_DONE,
    input wire logic I_NVM_ERR,
    input wire logic I_TX_READY,
    output logic O_NVM_WR_REQ,
    output logic [2:0] O_NVM_WR_DATA,
    output logic O_TX_VALID,
    output logic O_TX_BIT,
    output logic O_TX_EXT_PREAMBLE,
    output logic O_TO_ARBITRATE,
    output logic O_ITEM_HIDE,
    output logic O_IDENT_HIDE,
    output logic O_PSF,
    output logic O_ALARM_EN,
    output logic [15:0] O_CFG_WORD_ADDR
);

    localparam int TW = $clog2(P_TIMEOUT_CYC + 1);
    localparam int SH_W = `RTPC_LEN_UNVEIL;
    localparam int FW = `RTPC_FIELD_W;

    if (P_TIMEOUT_CYC < 2)
    begin : g_bad_timeout
        $error("P_TIMEOUT_CYC must be at least 2");
    end

    rtpc_fsm_t fsm_reg;
    rtpc_fsm_t fsm_next;
    rtpc_cmd_t cmd_reg;
    logic in_frame_reg;
    logic [6:0] bit_cnt_reg;
    logic [SH_W-1:0] rx_sh_reg;
    logic [2:0] cfg_reg;
    logic alarm_en_reg;
    logic [2:0] wr_data_reg;
    logic to_arb_reg;
    logic [24:0] tx_sh_reg;
    logic [24:0] tx_sh_next;
    logic [4:0] tx_idx_reg;
    logic [4:0] tx_idx_next;
    logic err_reply_reg;
    logic [TW-1:0] timer_reg;
    logic [FW-1:0] rx_crc;
    logic [FW-1:0] tx_crc;

    // receive side: bits only count inside a frame opened by frame-sync
    wire rx_take = in_frame_reg && I_BIT_VALID && !I_FRAME_SYNC;
    wire cnt_full = (bit_cnt_reg == 7'h7F);
    wire frame_done = I_FRAME_END && in_frame_reg && (fsm_reg == RTPC_ST_IDLE);

    wire is_veil = (bit_cnt_reg == 7'(`RTPC_LEN_VEIL))
        && (rx_sh_reg[`RTPC_LEN_VEIL-1 -: FW] == `RTPC_OP_VEIL);
    wire is_unveil = (bit_cnt_reg == 7'(`RTPC_LEN_UNVEIL))
        && (rx_sh_reg[`RTPC_LEN_UNVEIL-1 -: FW] == `RTPC_OP_UNVEIL);
    wire is_flag = (bit_cnt_reg == 7'(`RTPC_LEN_FLAG))
        && (rx_sh_reg[`RTPC_LEN_FLAG-1 -: FW] == `RTPC_OP_FLAG);
    wire [FW-1:0] rx_handle = rx_sh_reg[2*FW-1:FW];
    wire [31:0] rx_pwd_field = rx_sh_reg[2*FW+31:2*FW];
    wire flag_payload = rx_sh_reg[2*FW];
    wire crc_ok = (rx_crc == `RTPC_CRC_RESIDUE);

    wire good = frame_done && crc_ok && (is_veil || is_unveil || is_flag);
    wire st_arbish = (I_TAG_STATE == RTPC_ARBITRATE) || (I_TAG_STATE == RTPC_REPLY)
        || (I_TAG_STATE == RTPC_ACKNOWLEDGED);
    wire st_open = (I_TAG_STATE == RTPC_OPEN);
    wire st_sec = (I_TAG_STATE == RTPC_SECURED);
    wire handle_ok = (rx_handle == I_HANDLE);
    wire pwd_nz = (I_ACCESS_PWD != 32'h0000_0000);
    // a stale rn16 can never unmask the password
    wire pwd_ok = I_RN16_FRESH
        && ((rx_pwd_field ^ {I_RN16, I_RN16}) == I_ACCESS_PWD);

    wire do_veil = good && is_veil && st_sec && handle_ok && pwd_nz;
    wire do_unveil = good && is_unveil && (st_open || st_sec) && handle_ok && pwd_ok;
    wire bad_pwd = good && is_unveil && (st_open || st_sec) && handle_ok && !pwd_ok;
    wire do_flag = good && is_flag && st_sec && handle_ok && pwd_nz;
    wire go_arb = (good && st_arbish) || bad_pwd;
    wire start_write = do_veil || do_unveil || do_flag;

    wire [2:0] veil_data = {1'b1, 1'b1, cfg_reg[`RTPC_POS_PSF]};
    wire [2:0] unveil_data = {1'b0, 1'b0, cfg_reg[`RTPC_POS_PSF]};
    wire [2:0] flag_data = {cfg_reg[`RTPC_POS_ITEM_HIDE], cfg_reg[`RTPC_POS_IDENT_HIDE],
        flag_payload};
    wire [2:0] wr_data_sel = do_veil ? veil_data : (do_unveil ? unveil_data : flag_data);
    wire rtpc_cmd_t cmd_sel = do_veil ? RTPC_CMD_VEIL
        : (do_unveil ? RTPC_CMD_UNVEIL : RTPC_CMD_FLAG);

    wire tx_take = O_TX_VALID && I_TX_READY;
    wire [4:0] tx_last = err_reply_reg ? 5'(`RTPC_ERR_LEN - 1) : 5'(`RTPC_OK_LEN - 1);
    wire timed_out = (timer_reg == TW'(P_TIMEOUT_CYC - 1));
    wire write_ok = (fsm_reg == RTPC_ST_WRITE) && I_NVM_DONE && !I_NVM_ERR;

    // payload msb first, then the complemented crc
    wire [24:0] ok_frame = {1'b0, I_HANDLE, 8'h00};
    wire [24:0] err_frame = {1'b1, `RTPC_ERR_CODE, I_HANDLE};

    rtpc_crc16 #(
        .P_WIDTH(FW)
    ) u_rx_crc (
        .i_clk(I_SYS_CLK),
        .i_rst_n(I_RST_N),
        .i_clk_en(I_CLK_EN),
        .i_clear(I_FRAME_SYNC),
        .i_shift(rx_take),
        .i_bit(I_BIT_DATA),
        .o_crc(rx_crc)
    );

    rtpc_crc16 #(
        .P_WIDTH(FW)
    ) u_tx_crc (
        .i_clk(I_SYS_CLK),
        .i_rst_n(I_RST_N),
        .i_clk_en(I_CLK_EN),
        .i_clear(fsm_reg == RTPC_ST_WRITE),
        .i_shift(tx_take && (fsm_reg == RTPC_ST_SEND)),
        .i_bit(tx_sh_reg[24]),
        .o_crc(tx_crc)
    );

    always_comb
    begin
        fsm_next = fsm_reg;
        tx_sh_next = tx_sh_reg;
        tx_idx_next = tx_idx_reg;
        case (fsm_reg)
            RTPC_ST_IDLE:
                if (start_write)
                    fsm_next = RTPC_ST_WRITE;
            RTPC_ST_WRITE:
                if (I_NVM_DONE)
                begin
                    fsm_next = RTPC_ST_SEND;
                    tx_sh_next = I_NVM_ERR ? err_frame : ok_frame;
                    tx_idx_next = 5'h00;
                end
                else if (timed_out)
                    fsm_next = RTPC_ST_IDLE;
            RTPC_ST_SEND:
                if (tx_take)
                begin
                    tx_sh_next = {tx_sh_reg[23:0], 1'b0};
                    tx_idx_next = tx_idx_reg + 5'h01;
                    if (tx_idx_reg == tx_last)
                        fsm_next = RTPC_ST_CRC_LOAD;
                end
            RTPC_ST_CRC_LOAD:
            begin
                tx_sh_next = {~tx_crc, 9'h000};
                tx_idx_next = 5'h00;
                fsm_next = RTPC_ST_CRC;
            end
            RTPC_ST_CRC:
                if (tx_take)
                begin
                    tx_sh_next = {tx_sh_reg[23:0], 1'b0};
                    tx_idx_next = tx_idx_reg + 5'h01;
                    if (tx_idx_reg == 5'(FW - 1))
                        fsm_next = RTPC_ST_IDLE;
                end
            default:
                fsm_next = RTPC_ST_IDLE;
        endcase
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            in_frame_reg <= 1'b0;
            bit_cnt_reg <= 7'h00;
            rx_sh_reg <= '0;
        end
        else if (I_CLK_EN)
        begin
            if (I_FRAME_SYNC)
            begin
                in_frame_reg <= 1'b1;
                bit_cnt_reg <= 7'h00;
            end
            else if (I_FRAME_END)
                in_frame_reg <= 1'b0;
            if (rx_take)
            begin
                rx_sh_reg <= {rx_sh_reg[SH_W-2:0], I_BIT_DATA};
                // saturate so an overlong frame never aliases a valid length
                if (!cnt_full)
                    bit_cnt_reg <= bit_cnt_reg + 7'h01;
            end
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            fsm_reg <= RTPC_ST_IDLE;
            tx_sh_reg <= '0;
            tx_idx_reg <= 5'h00;
        end
        else if (I_CLK_EN)
        begin
            fsm_reg <= fsm_next;
            tx_sh_reg <= tx_sh_next;
            tx_idx_reg <= tx_idx_next;
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            cmd_reg <= RTPC_CMD_NONE;
            wr_data_reg <= `RTPC_CFG_RST;
            err_reply_reg <= 1'b0;
            to_arb_reg <= 1'b0;
            timer_reg <= '0;
        end
        else if (I_CLK_EN)
        begin
            to_arb_reg <= go_arb;
            if (start_write)
            begin
                cmd_reg <= cmd_sel;
                wr_data_reg <= wr_data_sel;
                timer_reg <= '0;
            end
            else if (fsm_reg == RTPC_ST_WRITE)
                timer_reg <= timer_reg + TW'(1);
            if ((fsm_reg == RTPC_ST_WRITE) && I_NVM_DONE)
                err_reply_reg <= I_NVM_ERR;
        end
    end

    // config copy: taken from memory at power-up, updated only after the write lands
    always_ff @(posedge I_SYS_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            cfg_reg <= `RTPC_CFG_RST;
            alarm_en_reg <= 1'b0;
        end
        else if (I_CLK_EN)
        begin
            if (I_NVM_LOAD)
            begin
                cfg_reg <= I_NVM_CFG;
                // alarm follows the flag only as of the next power-up
                alarm_en_reg <= I_NVM_CFG[`RTPC_POS_PSF];
            end
            else if (write_ok)
                cfg_reg <= wr_data_reg;
        end
    end

    assign O_NVM_WR_REQ = (fsm_reg == RTPC_ST_WRITE);
    assign O_NVM_WR_DATA = wr_data_reg;
    assign O_TX_VALID = (fsm_reg == RTPC_ST_SEND) || (fsm_reg == RTPC_ST_CRC);
    assign O_TX_BIT = tx_sh_reg[24];
    assign O_TX_EXT_PREAMBLE = O_TX_VALID;
    assign O_TO_ARBITRATE = to_arb_reg;
    assign O_ITEM_HIDE = cfg_reg[`RTPC_POS_ITEM_HIDE];
    assign O_IDENT_HIDE = cfg_reg[`RTPC_POS_IDENT_HIDE];
    assign O_PSF = cfg_reg[`RTPC_POS_PSF];
    assign O_ALARM_EN = alarm_en_reg;
    // word address for select matching by the inventory layer
    assign O_CFG_WORD_ADDR = `RTPC_CFG_WORD_ADDR;

    // helper: bits handed out in the current reply
    logic [5:0] sent_cnt_reg;
    always_ff @(posedge I_SYS_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
            sent_cnt_reg <= 6'h00;
        else if (I_CLK_EN)
        begin
            if (fsm_reg == RTPC_ST_WRITE)
                sent_cnt_reg <= 6'h00;
            else if (tx_take)
                sent_cnt_reg <= sent_cnt_reg + 6'h01;
        end
    end

    default clocking cb @(posedge I_SYS_CLK);
    endclocking
    default disable iff (!I_RST_N);

    no_sync_a: assert property (
        I_CLK_EN && !in_frame_reg && !I_FRAME_SYNC && I_BIT_VALID |=> $stable(bit_cnt_reg))
        else $error("bit counted outside a synced frame");
    bad_crc_a: assert property (
        I_CLK_EN && frame_done && !crc_ok |=> fsm_reg == RTPC_ST_IDLE && !O_TO_ARBITRATE)
        else $error("frame with bad crc was acted on");
    zero_pwd_a: assert property (
        I_CLK_EN && frame_done && (is_veil || is_flag) && !pwd_nz |=> !O_NVM_WR_REQ)
        else $error("command taken with zero password");
    veil_sets_a: assert property (
        I_CLK_EN && write_ok && cmd_reg == RTPC_CMD_VEIL |=> O_ITEM_HIDE && O_IDENT_HIDE)
        else $error("veil did not set both hide bits");
    unveil_clears_a: assert property (
        I_CLK_EN && write_ok && cmd_reg == RTPC_CMD_UNVEIL |=> !O_ITEM_HIDE && !O_IDENT_HIDE)
        else $error("unveil did not clear both hide bits");
    flag_value_a: assert property (
        I_CLK_EN && write_ok && cmd_reg == RTPC_CMD_FLAG |=> O_PSF == $past(wr_data_reg[0]))
        else $error("status flag differs from payload");
    wrong_pwd_a: assert property (
        I_CLK_EN && bad_pwd |=> O_TO_ARBITRATE && fsm_reg == RTPC_ST_IDLE && !O_TX_VALID)
        else $error("wrong password not sent to arbitrate silently");
    arb_state_a: assert property (
        I_CLK_EN && good && st_arbish |=> O_TO_ARBITRATE && !O_NVM_WR_REQ)
        else $error("arbitrating state did not return to arbitrate");
    pilot_a: assert property (
        O_TX_VALID |-> O_TX_EXT_PREAMBLE)
        else $error("reply without extended preamble");
    reply_len_a: assert property (
        I_CLK_EN && tx_take && fsm_reg == RTPC_ST_CRC && tx_idx_reg == 5'(FW - 1)
        && !err_reply_reg |-> sent_cnt_reg == 6'd32)
        else $error("success reply is not 33 bits");
    err_reply_a: assert property (
        I_CLK_EN && fsm_reg == RTPC_ST_WRITE && I_NVM_DONE && I_NVM_ERR |=> O_TX_VALID && O_TX_BIT)
        else $error("error reply header missing");
    alarm_hold_a: assert property (
        !I_NVM_LOAD |=> $stable(O_ALARM_EN))
        else $error("alarm enable moved without power-up load");

    veil_done_c: cover property (write_ok && cmd_reg == RTPC_CMD_VEIL);
    unveil_done_c: cover property (write_ok && cmd_reg == RTPC_CMD_UNVEIL);
    flag_done_c: cover property (write_ok && cmd_reg == RTPC_CMD_FLAG);
    err_sent_c: cover property (fsm_reg == RTPC_ST_CRC && err_reply_reg);

endmodule

// file: logic/rtpc_crc16.sv
`timescale 1ns/100ps
`include "rtpc_cfg.svh"

module rtpc_crc16 #(
    parameter int P_WIDTH = 16
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_clk_en,
    input wire logic i_clear,
    input wire logic i_shift,
    input wire logic i_bit,
    output logic [P_WIDTH-1:0] o_crc
);

    if (P_WIDTH != 16)
    begin : g_bad_width
        $error("rtpc_crc16 serves only a 16-bit crc");
    end

    logic [P_WIDTH-1:0] crc_reg;
    logic [P_WIDTH-1:0] crc_next;
    wire feedback = i_bit ^ crc_reg[P_WIDTH-1];

    assign crc_next = {crc_reg[P_WIDTH-2:0], 1'b0} ^ (feedback ? `RTPC_CRC_POLY : 16'h0000);
    assign o_crc = crc_reg;

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            crc_reg <= `RTPC_CRC_PRESET;
        else if (i_clk_en)
        begin
            if (i_clear)
                crc_reg <= `RTPC_CRC_PRESET;
            else if (i_shift)
                crc_reg <= crc_next;
        end
    end

endmodule

// file: logic/rtpc_pkg.sv
package rtpc_pkg;

    typedef enum logic [2:0] {
        RTPC_READY,
        RTPC_ARBITRATE,
        RTPC_REPLY,
        RTPC_ACKNOWLEDGED,
        RTPC_OPEN,
        RTPC_SECURED,
        RTPC_KILLED
    } rtpc_tag_state_t;

    typedef enum logic [1:0] {
        RTPC_CMD_NONE,
        RTPC_CMD_VEIL,
        RTPC_CMD_UNVEIL,
        RTPC_CMD_FLAG
    } rtpc_cmd_t;

    typedef enum logic [2:0] {
        RTPC_ST_IDLE,
        RTPC_ST_WRITE,
        RTPC_ST_SEND,
        RTPC_ST_CRC_LOAD,
        RTPC_ST_CRC
    } rtpc_fsm_t;

endpackage

// file: sim/rtpc_reader_model.sv
`timescale 1ns/100ps

module rtpc_reader_model (
    input wire logic i_clk,
    input wire logic i_slow,
    input wire logic i_tx_valid,
    input wire logic i_tx_bit,
    input wire logic i_tx_ext,
    output logic o_frame_sync,
    output logic o_bit_valid,
    output logic o_bit_data,
    output logic o_frame_end,
    output logic o_tx_ready
);
    logic [40:0] rx = 41'h0;
    int cnt = 0;
    logic ext_bad = 1'h0;
    logic ready_ph = 1'h0;

    initial
    begin
        o_frame_sync = 1'h0;
        o_bit_valid = 1'h0;
        o_bit_data = 1'h0;
        o_frame_end = 1'h0;
    end

    // a slow reader takes a reply bit only every other cycle
    always @(posedge i_clk) ready_ph <= ~ready_ph;
    assign o_tx_ready = ~i_slow | ready_ph;

    // keeps listening for the whole reply window
    always @(posedge i_clk)
    begin
        if (i_tx_valid && o_tx_ready)
        begin
            rx <= {rx[39:0], i_tx_bit};
            cnt <= cnt + 1;
        end
        if (i_tx_valid && !i_tx_ext)
            ext_bad <= 1'h1;
    end

    // frame-sync first when sy is set, then bits msb first, crc already appended
    task automatic send(input logic [95:0] fr, input int n, input logic sy);
        @(posedge i_clk);
        o_frame_sync <= sy;
        for (int i = n - 1; i >= 0; i--)
        begin
            @(posedge i_clk);
            o_frame_sync <= 1'h0;
            o_bit_valid <= 1'h1;
            o_bit_data <= fr[i];
        end
        @(posedge i_clk);
        o_bit_valid <= 1'h0;
        o_frame_end <= 1'h1;
        // released line must not keep showing the last bit
        o_bit_data <= ~o_bit_data;
        @(posedge i_clk);
        o_frame_end <= 1'h0;
    endtask
endmodule

// file: sim/tb_top.sv
`timescale 1ns/100ps
`include "rtpc_cfg.svh"

module tb_top
    import rtpc_pkg::*;
;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    rtpc_tag_state_t tag_state = RTPC_READY;
    logic [15:0] hnd = 16'hBEEF;
    logic [15:0] rn = 16'h1234;
    logic fresh = 1'h1;
    logic [31:0] pwd = 32'h5A5A3C3C;
    logic nvm_load = 1'h0;
    logic [2:0] nvm_cfg = 3'h0;
    logic nvm_done = 1'h0;
    logic nvm_err = 1'h0;
    logic rdr_slow = 1'h0;
    logic clk_en = 1'h1;
    logic fsync, bvalid, bdata, fend, tx_ready, wr_req, tx_valid, tx_bit, tx_ext;
    logic to_arb, item_h, ident_h, product_status_flag, alarm;
    logic [2:0] wr_data;
    logic [15:0] cfg_addr;
    int fail_count = 0;
    int comparisons = 0;

    always #2.5 clk = ~clk;

    rtpc_cmd_handler #(.P_TIMEOUT_CYC(50)) dut_u (
        .I_SYS_CLK(clk), .I_RST_N(rst_n), .I_CLK_EN(clk_en), .I_FRAME_SYNC(fsync),
        .I_BIT_VALID(bvalid), .I_BIT_DATA(bdata), .I_FRAME_END(fend),
        .I_TAG_STATE(tag_state), .I_HANDLE(hnd), .I_RN16(rn), .I_RN16_FRESH(fresh),
        .I_ACCESS_PWD(pwd), .I_NVM_LOAD(nvm_load), .I_NVM_CFG(nvm_cfg),
        .I_NVM_DONE(nvm_done), .I_NVM_ERR(nvm_err), .I_TX_READY(tx_ready),
        .O_NVM_WR_REQ(wr_req), .O_NVM_WR_DATA(wr_data), .O_TX_VALID(tx_valid),
        .O_TX_BIT(tx_bit), .O_TX_EXT_PREAMBLE(tx_ext), .O_TO_ARBITRATE(to_arb),
        .O_ITEM_HIDE(item_h), .O_IDENT_HIDE(ident_h), .O_PSF(product_status_flag),
        .O_ALARM_EN(alarm), .O_CFG_WORD_ADDR(cfg_addr));

    rtpc_reader_model rdr_u (
        .i_clk(clk), .i_slow(rdr_slow), .i_tx_valid(tx_valid), .i_tx_bit(tx_bit),
        .i_tx_ext(tx_ext), .o_frame_sync(fsync), .o_bit_valid(bvalid),
        .o_bit_data(bdata), .o_frame_end(fend), .o_tx_ready(tx_ready));

    task automatic give_verdict;
        if (fail_count == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic check(input logic [40:0] seen, input logic [40:0] exp, input string msg);
        comparisons++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
        end
    endtask

    function automatic logic [15:0] crc16(input logic [79:0] d, input int n);
        logic [15:0] c;
        c = `RTPC_CRC_PRESET;
        for (int i = n - 1; i >= 0; i--)
            c = (c[15] ^ d[i]) ? {c[14:0], 1'h0} ^ `RTPC_CRC_POLY : {c[14:0], 1'h0};
        return c;
    endfunction

    function automatic logic [95:0] mk(input logic [79:0] body, input int n);
        return {body, 16'h0} | {80'h0, ~crc16(body, n)};
    endfunction

    function automatic logic [95:0] veil(input logic [15:0] h);
        return mk({48'h0, `RTPC_OP_VEIL, h}, 32);
    endfunction

    function automatic logic [95:0] unveil(input logic [31:0] p, input logic [15:0] h);
        return mk({16'h0, `RTPC_OP_UNVEIL, p ^ {rn, rn}, h}, 64);
    endfunction

    function automatic logic [95:0] flag_f(input logic b, input logic [15:0] h);
        return mk({47'h0, `RTPC_OP_FLAG, b, h}, 33);
    endfunction

    function automatic logic [40:0] reply(input logic er);
        logic [79:0] p;
        p = er ? {55'h0, 1'h1, `RTPC_ERR_CODE, hnd} : {64'h0, hnd};
        return er ? {p[24:0], ~crc16(p, 25)} : {8'h0, p[16:0], ~crc16(p, 17)};
    endfunction

    task automatic load(input logic [2:0] c);
        @(posedge clk);
        nvm_load <= 1'h1;
        nvm_cfg <= c;
        @(posedge clk);
        nvm_load <= 1'h0;
        @(negedge clk);
    endtask

    // kind: 0 ignored, 1 back to arbitrate, 2 stored and answered, 3 store fails, 4 no answer
    task automatic do_cmd(input rtpc_tag_state_t st, input logic [95:0] fr, input int n,
        input logic sy, input int kind, input logic [2:0] wd);
        logic arb;
        logic wr;
        int c0;
        int ln;
        logic [2:0] cfg0;
        arb = 1'h0;
        wr = 1'h0;
        c0 = rdr_u.cnt;
        cfg0 = {item_h, ident_h, product_status_flag};
        ln = (kind == 3) ? 41 : ((kind == 4) ? 0 : 33);
        @(posedge clk);
        tag_state <= st;
        rdr_u.send(fr, n, sy);
        repeat (3)
        begin
            @(negedge clk);
            arb |= to_arb;
            wr |= wr_req;
        end
        check(arb, kind == 1, "arbitrate request");
        check(wr, kind >= 2, "write request");
        if (kind >= 2)
        begin
            check(wr_data, wd, "write data");
            @(posedge clk);
            nvm_done <= (kind != 4);
            nvm_err <= (kind == 3);
            @(posedge clk);
            nvm_done <= 1'h0;
            nvm_err <= 1'h0;
            for (int i = 0; i < 400 && rdr_u.cnt - c0 < ln; i++)
                @(negedge clk);
            repeat ((kind == 4) ? 60 : 4) @(negedge clk);
            check(rdr_u.cnt - c0, ln, "reply length");
            if (rdr_u.cnt - c0 < ln)
                give_verdict();
            if (kind == 4)
                check(wr_req, 1'h0, "write given up");
            else
                check(kind == 3 ? rdr_u.rx : {8'h0, rdr_u.rx[32:0]}, reply(kind == 3),
                    "reply");
            if (kind == 2)
                cfg0 = wd;
        end
        else
        begin
            repeat (4) @(negedge clk);
            check(rdr_u.cnt - c0, 0, "silent");
        end
        check({item_h, ident_h, product_status_flag}, cfg0, "config bits");
        check(rdr_u.ext_bad, 1'h0, "pilot preamble");
    endtask

    initial
    begin
        repeat (2) @(posedge clk);
        rst_n <= 1'h1;
        @(negedge clk);
        check(cfg_addr, `RTPC_CFG_WORD_ADDR, "word address");
        check({wr_req, tx_valid, to_arb, item_h, ident_h, product_status_flag, alarm}, 7'h0,
            "reset outputs");
        load(3'h1);
        check({item_h, ident_h, product_status_flag, alarm}, 4'h3, "load");
        @(posedge clk);
        clk_en <= 1'h0;
        load(3'h6);
        check({item_h, ident_h, product_status_flag, alarm}, 4'h3, "frozen load");
        @(posedge clk);
        clk_en <= 1'h1;
        do_cmd(RTPC_SECURED, veil(hnd), 48, 1'h1, 2, 3'h7);
        @(posedge clk);
        pwd <= 32'h0;
        do_cmd(RTPC_SECURED, veil(hnd), 48, 1'h1, 0, 3'h0);
        do_cmd(RTPC_SECURED, flag_f(1'h1, hnd), 49, 1'h1, 0, 3'h0);
        @(posedge clk);
        pwd <= 32'h5A5A3C3C;
        for (int i = 0; i < 7; i++)
            if (i != 5)
                do_cmd(rtpc_tag_state_t'(i[2:0]), veil(hnd), 48, 1'h1,
                    (i >= 1 && i <= 3) ? 1 : 0, 3'h0);
        do_cmd(RTPC_SECURED, veil(hnd), 48, 1'h0, 0, 3'h0);
        do_cmd(RTPC_SECURED, veil(hnd ^ 16'h1), 48, 1'h1, 0, 3'h0);
        @(posedge clk);
        fresh <= 1'h0;
        do_cmd(RTPC_OPEN, unveil(pwd, hnd), 80, 1'h1, 1, 3'h0);
        @(posedge clk);
        fresh <= 1'h1;
        do_cmd(RTPC_SECURED, unveil(~pwd, hnd), 80, 1'h1, 1, 3'h0);
        do_cmd(RTPC_SECURED, unveil(pwd, hnd) ^ 96'h1, 80, 1'h1, 0, 3'h0);
        do_cmd(RTPC_OPEN, unveil(pwd, hnd ^ 16'h8000), 80, 1'h1, 0, 3'h0);
        do_cmd(RTPC_OPEN, unveil(pwd, hnd), 80, 1'h1, 2, 3'h1);
        @(posedge clk);
        rdr_slow <= 1'h1;
        do_cmd(RTPC_SECURED, flag_f(1'h0, hnd), 49, 1'h1, 2, 3'h0);
        @(posedge clk);
        rdr_slow <= 1'h0;
        check(alarm, 1'h1, "alarm before reload");
        load(3'h0);
        check(alarm, 1'h0, "alarm after reload");
        do_cmd(RTPC_OPEN, flag_f(1'h1, hnd), 49, 1'h1, 0, 3'h0);
        do_cmd(RTPC_SECURED, flag_f(1'h1, hnd ^ 16'h1), 49, 1'h1, 0, 3'h0);
        do_cmd(RTPC_SECURED, flag_f(1'h1, hnd) ^ 96'h100, 49, 1'h1, 0, 3'h0);
        do_cmd(RTPC_ACKNOWLEDGED, flag_f(1'h1, hnd), 49, 1'h1, 1, 3'h0);
        do_cmd(RTPC_SECURED, flag_f(1'h1, hnd), 49, 1'h1, 3, 3'h1);
        do_cmd(RTPC_SECURED, flag_f(1'h1, hnd), 49, 1'h1, 2, 3'h1);
        do_cmd(RTPC_SECURED, veil(hnd), 48, 1'h1, 4, 3'h7);
        check(alarm, 1'h0, "alarm waits for power-up");
        give_verdict();
    end
endmodule
